// [common/sof_pkg.sv]
/*
 * Shared constants for the slow oscillator control and flag block:
 * register offsets, field positions, reset values and warm-up counts.
 * Assumes a 32-bit APB register bus and byte addresses as offsets.
 */
package sof_pkg;

    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  OFS_INT_EN_CLR = 8'h00;
    localparam logic [7:0]  OFS_INT_EN_SET = 8'h04;
    localparam logic [7:0]  OFS_INT_FLAGS  = 8'h08;
    localparam logic [7:0]  OFS_STATUS     = 8'h0C;
    localparam logic [7:0]  OFS_XTAL_CFG   = 8'h14;

    // ---------------------------------------------------------------
    // crystal_osc_config fields
    // ---------------------------------------------------------------
    localparam int          CFG_W          = 16;
    localparam logic [15:0] CFG_RESET      = 16'h0080;
    localparam logic [15:0] CFG_WMASK      = 16'h17DE;
    localparam int          CFG_ENABLE     = 1;
    localparam int          CFG_XTAL_MODE  = 2;
    localparam int          CFG_FULL_GATE  = 3;
    localparam int          CFG_SLOW_GATE  = 4;
    localparam int          CFG_RUN_SLEEP  = 6;
    localparam int          CFG_ON_REQUEST = 7;
    localparam int          CFG_WARM_LSB   = 8;
    localparam int          CFG_LOCK       = 12;

    // ---------------------------------------------------------------
    // flag, enable and status layout (shared bit positions)
    // ---------------------------------------------------------------
    localparam int          FLAG_W         = 3;
    localparam logic [2:0]  FLAG_RESET     = 3'h0;
    localparam int          FLAG_XTAL_RDY  = 0;
    localparam int          FLAG_RC_RDY    = 1;
    localparam int          FLAG_CLK_FAIL  = 2;
    localparam int          STAT_OSC_RUN   = 3;

    // ---------------------------------------------------------------
    // warm-up timing counts
    // ---------------------------------------------------------------
    localparam int          REF_CNT_W      = 18;
    localparam logic [1:0]  XTAL_WARM_CYC  = 2'h3;

    typedef enum {WARM_IDLE, WARM_REF, WARM_XTAL, WARM_DONE} sof_warm_state_t;

    // reference oscillator cycles per warm-up code
    function automatic logic [17:0] sof_ref_cycles(input logic [2:0] code);
        logic [17:0] n;
        n = 18'h00001;
        unique case (code)
            3'h0: n = 18'h00001;
            3'h1: n = 18'h00020;
            3'h2: n = 18'h00800;
            3'h3: n = 18'h01000;
            3'h4: n = 18'h04000;
            3'h5: n = 18'h08000;
            3'h6: n = 18'h10000;
            3'h7: n = 18'h20000;
        endcase
        return n;
    endfunction

endpackage

// [logic/sof_warmup.sv]
/*
 * Crystal warm-up timer: counts reference oscillator ticks chosen by the
 * warm-up code, then three crystal ticks, then reports ready.
 * Assumes tick inputs are one-cycle pulses already synchronised to pclk.
 */
`timescale 1ns/1ns
module sof_warmup
    import sof_pkg::*;
#(
    parameter int REF_SHIFT = 0
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        osc_run,
    input  wire logic [2:0]  warm_sel,
    input  wire logic        ref_tick,
    input  wire logic        xtal_tick,
    output logic             warm_ready
);
    import sof_pkg::*;

    sof_warm_state_t             state_reg, state_next;
    logic [sof_pkg::REF_CNT_W-1:0] cnt_reg, cnt_next;
    logic [sof_pkg::REF_CNT_W-1:0] target;

    // shortened target keeps a minimum of one tick for simulation
    assign target = ((sof_ref_cycles(warm_sel) >> REF_SHIFT) == '0) ? 18'h00001
                  : (sof_ref_cycles(warm_sel) >> REF_SHIFT);

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    // dropping the run request restarts the whole wait
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        if (!osc_run)
        begin
            state_next = WARM_IDLE;
            cnt_next   = '0;
        end
        else
        begin
            unique case (state_reg)
                WARM_IDLE:
                begin
                    state_next = WARM_REF;
                    cnt_next   = '0;
                end
                WARM_REF:
                    if (ref_tick)
                    begin
                        if (cnt_reg + 18'h00001 >= target)
                        begin
                            state_next = WARM_XTAL;
                            cnt_next   = '0;
                        end
                        else
                            cnt_next = cnt_reg + 18'h00001;
                    end
                WARM_XTAL:
                    if (xtal_tick)
                    begin
                        if (cnt_reg[1:0] + 2'h1 == XTAL_WARM_CYC)
                            state_next = WARM_DONE;
                        cnt_next = cnt_reg + 18'h00001;
                    end
                WARM_DONE:
                    state_next = WARM_DONE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg  <= WARM_IDLE;
            cnt_reg    <= '0;
            warm_ready <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            warm_ready <= (state_next == WARM_DONE);
        end
    end

endmodule

// [logic/sof_top.sv]
/*
 * Slow oscillator control and interrupt flags: crystal configuration
 * register, warm-up timing, sticky ready / failure flags, one interrupt.
 * Assumes an APB master on pclk; oscillator pins are asynchronous.
 */
// Function
// - clock failure flag sets on rising failure status; irq when enabled
// - rc ready flag sets on rising rc status; irq only when enabled
// - crystal ready flag sets on rising crystal status; irq when enabled
// - writing one clears a flag; writing zero leaves it alone
// - lock bit set freezes the crystal configuration against writes
// - warm-up counted on reference oscillator ticks, code selects count
// - codes 0..7 give 1..131072 reference ticks plus 3 crystal ticks
// - standby stops oscillator unless clock requested or on-request is zero
`timescale 1ns/1ns
module sof_top
    import sof_pkg::*;
#(
    parameter int REF_SHIFT = 0
)
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [sof_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       ref_osc_clk_pin,
    input  wire logic                       crystal_clk_pin,
    input  wire logic                       rc_ready_pin,
    input  wire logic                       clock_fail_pin,
    input  wire logic                       standby_sleep,
    input  wire logic                       periph_clock_request,
    output logic                            crystal_osc_run,
    output logic                            crystal_mode_select,
    output logic                            full_rate_output_gate,
    output logic                            slow_output_gate,
    output logic                            run_in_sleep,
    output logic                            irq
);
    import sof_pkg::*;

    // ---------------------------------------------------------------
    // state declarations
    // ---------------------------------------------------------------
    logic [3:0]               sync1_reg, sync2_reg, sync3_reg;
    logic [3:0]               filt_reg, filt_next;
    logic [3:0]               rise;
    logic [CFG_W-1:0]         cfg_reg, cfg_next;
    logic [FLAG_W-1:0]        flag_reg, flag_next;
    logic [FLAG_W-1:0]        en_reg, en_next;
    logic [FLAG_W-1:0]        stat_now;
    logic [FLAG_W-1:0]        stat_reg;
    logic [FLAG_W-1:0]        stat_rise;
    logic [FLAG_W-1:0]        w1c;
    logic                     run_reg, run_next;
    logic                     irq_next;
    logic                     warm_ready;
    logic                     wr_fire;
    logic                     setup;
    logic [31:0]              rdata_next;
    logic                     hit;
    logic                     wr_cfg;
    logic                     wr_flags;
    logic                     wr_en_set;
    logic                     wr_en_clr;
    logic                     pready_next;
    logic                     pslverr_next;
    logic [31:0]              prdata_next;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    // bit 0 reference clock, 1 crystal clock, 2 rc ready, 3 clock fail;
    // a change is taken only once stages two and three agree,
    // and only stage two ever reads stage one
    always_comb
    begin
        filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
        rise      = filt_next & ~filt_reg;
    end

    // pin stages and the agreed level, all clear in reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            sync3_reg <= 4'h0;
            filt_reg  <= 4'h0;
        end
        else
        begin
            sync1_reg <= {clock_fail_pin, rc_ready_pin, crystal_clk_pin, ref_osc_clk_pin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= filt_next;
        end
    end

    // ---------------------------------------------------------------
    // warm-up timer
    // ---------------------------------------------------------------
    // ticks are rising edges of the sampled slow clocks, so both slow
    // clocks must stay well below half of pclk
    // the timer restarts from scratch whenever the run request drops
    sof_warmup #(
        .REF_SHIFT  (REF_SHIFT)
    ) u_warmup (
        .pclk       (pclk),
        .presetn    (presetn),
        .osc_run    (run_reg),
        .warm_sel   (cfg_reg[CFG_WARM_LSB +: 3]),
        .ref_tick   (rise[0]),
        .xtal_tick  (rise[1]),
        .warm_ready (warm_ready)
    );

    // ---------------------------------------------------------------
    // oscillator run request
    // ---------------------------------------------------------------
    // outside standby the run request follows the enable bit alone;
    // in standby the oscillator keeps running only if a clock is requested or on-request is zero
    always_comb
    begin
        run_next = cfg_reg[CFG_ENABLE]
                 & (~standby_sleep
                    | periph_clock_request
                    | ~cfg_reg[CFG_ON_REQUEST]);
    end

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    // true when the bus address selects the given register;
    // shared by all the write strobes below
    function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction

    // answer is prepared in the setup cycle so the access phase lasts
    // exactly one cycle and every bus output is a flip-flop
    assign setup   = psel & ~penable;
    assign wr_fire = psel & penable & pready & pwrite & ~pslverr;
    assign hit     = (paddr == OFS_INT_EN_CLR) | (paddr == OFS_INT_EN_SET)
                   | (paddr == OFS_INT_FLAGS)  | (paddr == OFS_STATUS)
                   | (paddr == OFS_XTAL_CFG);

    // read mux: unimplemented bits and unmapped offsets read as zero
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        unique case (paddr)
            OFS_INT_EN_CLR: rdata_next[FLAG_W-1:0] = en_reg;
            OFS_INT_EN_SET: rdata_next[FLAG_W-1:0] = en_reg;
            OFS_INT_FLAGS:  rdata_next[FLAG_W-1:0] = flag_reg;
            OFS_STATUS:     rdata_next[STAT_OSC_RUN:0] = {run_reg, stat_reg};
            OFS_XTAL_CFG:   rdata_next[CFG_W-1:0] = cfg_reg;
            default:        rdata_next = 32'h0000_0000;
        endcase
    end

    // the answer stands for the one access cycle only; zero otherwise,
    // so an idle bus never shows stale register contents and a late
    // sample by the master cannot pick up the previous word
    always_comb
    begin
        pready_next  = setup;
        pslverr_next = setup & ~hit;
        prdata_next  = 32'h0000_0000;
        if (setup)
            prdata_next = rdata_next;
    end

    // ---------------------------------------------------------------
    // register write strobes
    // ---------------------------------------------------------------
    // each fires only at the accepted access edge of a mapped write,
    // so a refused write changes nothing; flags and enables live in
    // lane 0 and need its strobe
    always_comb
    begin
        wr_cfg    = wr_fire & addr_is(paddr, OFS_XTAL_CFG);
        wr_flags  = wr_fire & pstrb[0] & addr_is(paddr, OFS_INT_FLAGS);
        wr_en_set = wr_fire & pstrb[0] & addr_is(paddr, OFS_INT_EN_SET);
        wr_en_clr = wr_fire & pstrb[0] & addr_is(paddr, OFS_INT_EN_CLR);
    end

    // ---------------------------------------------------------------
    // configuration register
    // ---------------------------------------------------------------
    // once locked only a reset reopens it, the lock bit included;
    // reserved bits are masked off so they always read back as zero
    always_comb
    begin
        cfg_next = cfg_reg;
        if (wr_cfg && !cfg_reg[CFG_LOCK])
        begin
            if (pstrb[0])
                cfg_next[7:0] = pwdata[7:0] & CFG_WMASK[7:0];
            if (pstrb[1])
                cfg_next[15:8] = pwdata[15:8] & CFG_WMASK[15:8];
        end
    end

    // ---------------------------------------------------------------
    // interrupt enables, status and flags
    // ---------------------------------------------------------------
    // status bits: crystal ready from the timer, rc ready and failure
    // detection from the filtered pins
    always_comb
    begin
        stat_now                = '0;
        stat_now[FLAG_XTAL_RDY] = warm_ready;
        stat_now[FLAG_RC_RDY]   = filt_reg[2];
        stat_now[FLAG_CLK_FAIL] = filt_reg[3];
        stat_rise               = stat_now & ~stat_reg;
        w1c                     = '0;
        if (wr_flags)
            w1c = pwdata[FLAG_W-1:0];
    end

    // enables: set and clear sit at separate offsets, never both at once
    always_comb
    begin
        en_next = en_reg;
        if (wr_en_set)
            en_next = en_reg | pwdata[FLAG_W-1:0];
        if (wr_en_clr)
            en_next = en_reg & ~pwdata[FLAG_W-1:0];
    end

    // set beats clear when both land in the same cycle, so an event
    // arriving during the clearing write is never lost
    always_comb
    begin
        flag_next                = (flag_reg & ~w1c) | stat_rise;
        flag_next[FLAG_XTAL_RDY] = (flag_reg[FLAG_XTAL_RDY] & ~w1c[FLAG_XTAL_RDY])
                                 | stat_rise[FLAG_XTAL_RDY];
        flag_next[FLAG_RC_RDY]   = (flag_reg[FLAG_RC_RDY] & ~w1c[FLAG_RC_RDY])
                                 | stat_rise[FLAG_RC_RDY];
        flag_next[FLAG_CLK_FAIL] = (flag_reg[FLAG_CLK_FAIL] & ~w1c[FLAG_CLK_FAIL])
                                 | stat_rise[FLAG_CLK_FAIL];
    end

    // level interrupt from registered flags and enables only
    always_comb
    begin
        irq_next = |(flag_reg & en_reg);
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    // all state except the pin stages, the agreed level and the warm-up timer moves only here; reset values match an idle bus
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg  <= CFG_RESET;
            flag_reg <= FLAG_RESET;
            en_reg   <= FLAG_RESET;
            stat_reg <= FLAG_RESET;
            run_reg  <= 1'b0;
            irq      <= 1'b0;
            prdata   <= 32'h0000_0000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end
        else
        begin
            cfg_reg  <= cfg_next;
            flag_reg <= flag_next;
            en_reg   <= en_next;
            stat_reg <= stat_now;
            run_reg  <= run_next;
            irq      <= irq_next;
            prdata   <= prdata_next;
            pready   <= pready_next;
            pslverr  <= pslverr_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs to the analog oscillator and clock tree
    // ---------------------------------------------------------------
    // straight register bits, so the analog side never sees a glitch
    assign crystal_osc_run       = run_reg;
    assign crystal_mode_select   = cfg_reg[CFG_XTAL_MODE];
    assign full_rate_output_gate = cfg_reg[CFG_FULL_GATE];
    assign slow_output_gate      = cfg_reg[CFG_SLOW_GATE];
    assign run_in_sleep          = cfg_reg[CFG_RUN_SLEEP];

endmodule

// [tb/sof_top_chk.sv]
/*
 * Checker for sof_top: bus timing and decode, config outputs, run control,
 * irq masking and crystal status drop.
 * Assumes binding to sof_top and a 32-bit APB master on pclk.
 */
`timescale 1ns/1ns
module sof_top_chk
    import sof_pkg::*;
(
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [sof_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [3:0]                 pstrb,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       standby_sleep,
    input wire logic                       periph_clock_request,
    input wire logic                       crystal_osc_run,
    input wire logic                       crystal_mode_select,
    input wire logic                       full_rate_output_gate,
    input wire logic                       slow_output_gate,
    input wire logic                       run_in_sleep,
    input wire logic                       irq
);
    import sof_pkg::*;
    logic [15:0] shadow_reg;
    logic [15:0] shadow_next;
    logic        wr_cfg;
    logic        run_want;
    logic        unmapped;
    assign wr_cfg   = psel && penable && pready && pwrite && paddr == OFS_XTAL_CFG;
    assign unmapped = !(paddr inside {OFS_INT_EN_CLR, OFS_INT_EN_SET, OFS_INT_FLAGS,
                                      OFS_STATUS, OFS_XTAL_CFG});
    // expected run level; a stopped standby clock saves power
    assign run_want = shadow_reg[CFG_ENABLE] && (!standby_sleep || periph_clock_request
                      || !shadow_reg[CFG_ON_REQUEST]);
    // shadow of the config register, frozen once its lock bit is seen
    always_comb
    begin
        shadow_next = shadow_reg;
        if (wr_cfg && !shadow_reg[CFG_LOCK] && pstrb[0])
            shadow_next[7:0] = pwdata[7:0] & CFG_WMASK[7:0];
        if (wr_cfg && !shadow_reg[CFG_LOCK] && pstrb[1])
            shadow_next[15:8] = pwdata[15:8] & CFG_WMASK[15:8];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shadow_reg <= CFG_RESET;
        else
            shadow_reg <= shadow_next;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
        else $error("no ready after setup");
    ready_in_access_a: assert property (pready |-> psel && penable && $past(psel))
        else $error("ready outside access");
    slverr_decode_a: assert property (pready |-> pslverr == unmapped)
        else $error("error response wrong for address");
    idle_bus_zero_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside access");
    cfg_outputs_a: assert property ({crystal_mode_select, full_rate_output_gate,
        slow_output_gate, run_in_sleep} == {shadow_reg[CFG_XTAL_MODE], shadow_reg[CFG_FULL_GATE],
        shadow_reg[CFG_SLOW_GATE], shadow_reg[CFG_RUN_SLEEP]}) else $error("config outputs wrong");
    run_rule_a: assert property ($stable(run_want) |-> crystal_osc_run == run_want)
        else $error("oscillator run level wrong");
    irq_mask_off_a: assert property (psel && penable && pready && pwrite && pstrb[0]
        && paddr == OFS_INT_EN_CLR && pwdata[2:0] == 3'h7 |-> ##[1:2] !irq)
        else $error("irq stays with all enables cleared");
    status_stop_a: assert property (pready && !pwrite && paddr == OFS_STATUS
        && !(crystal_osc_run || $past(crystal_osc_run) || $past(crystal_osc_run, 2)
        || $past(crystal_osc_run, 3)) |-> !prdata[0]) else $error("crystal ready while stopped");
endmodule

bind sof_top sof_top_chk u_sof_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby_sleep(standby_sleep),
    .periph_clock_request(periph_clock_request), .crystal_osc_run(crystal_osc_run),
    .crystal_mode_select(crystal_mode_select), .full_rate_output_gate(full_rate_output_gate),
    .slow_output_gate(slow_output_gate), .run_in_sleep(run_in_sleep), .irq(irq));

// [tb/sof_top_tb.sv]
/*
 * Self-checking bench for sof_top: registers, flags, irq, warm-up codes,
 * standby run control and write lock.
 * Assumes the checker file is compiled with it; reference ticks shortened.
 */
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value at %0t got %h expected %h", $time, (a), (b)); end end
module sof_top_tb;
    import sof_pkg::*;
    localparam int SH = 10;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [3:0]        pstrb;
    logic              ref_clk, xtal_clk, rc_pin, fail_pin, sby, req;
    logic              run, xmode, full_g, slow_g, rsleep, irq;
    int                miscompares, samples_checked, rc;
    sof_top #(.REF_SHIFT(SH)) u_sof_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_osc_clk_pin(ref_clk),
        .crystal_clk_pin(xtal_clk), .rc_ready_pin(rc_pin), .clock_fail_pin(fail_pin),
        .standby_sleep(sby), .periph_clock_request(req), .crystal_osc_run(run),
        .crystal_mode_select(xmode), .full_rate_output_gate(full_g),
        .slow_output_gate(slow_g), .run_in_sleep(rsleep), .irq(irq));
    initial
    begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    // oscillator pins: reference period 4 clocks, crystal period 6 clocks
    always @(posedge pclk)
    begin
        rc <= rc + 1;
        if (rc % 2 == 1) ref_clk <= !ref_clk;
        if (rc % 3 == 2) xtal_clk <= !xtal_clk;
    end
    task test_done;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, wr, a, d, 4'hF};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 50) begin miscompares++; test_done; end
    endtask
    // bounded waits; a missing irq shows in the comparison after it
    task automatic settle(input int c);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < c) begin @(posedge pclk); n++; end
    endtask
    task automatic pin(input int b, input logic v);
        @(posedge pclk);
        if (b == 1) rc_pin <= v; else fail_pin <= v;
    endtask
    task t_regs;
        apb(0, OFS_XTAL_CFG, 0); `CHK(rd, 32'h80)
        apb(0, OFS_INT_FLAGS, 0); `CHK(rd, 32'h0)
        apb(1, 8'h10, 32'hFFFF); `CHK(err, 1'b1)
        apb(0, OFS_XTAL_CFG, 0); `CHK(rd, 32'h80)
    endtask
    // flag set on rising status, irq only when enabled, write-one clears
    task automatic t_flag(input int b);
        apb(1, OFS_INT_EN_SET, 1 << b); pin(b, 1); settle(20);
        `CHK(irq, 1'b1)
        apb(1, OFS_INT_FLAGS, 0); apb(0, OFS_INT_FLAGS, 0); `CHK(rd, 32'(1 << b))
        apb(1, OFS_INT_FLAGS, 1 << b); apb(0, OFS_INT_FLAGS, 0); `CHK(rd, 32'h0)
        settle(3); `CHK(irq, 1'b0)
        apb(1, OFS_INT_EN_CLR, 7); pin(b, 0); settle(8); pin(b, 1); settle(10);
        apb(0, OFS_INT_FLAGS, 0); `CHK(rd, 32'(1 << b))
        `CHK(irq, 1'b0)
        apb(1, OFS_INT_FLAGS, 7); pin(b, 0);
    endtask
    // each warm-up code: ready after its reference ticks plus crystal ticks
    task automatic t_warm;
        int n[8] = '{1, 32, 2048, 4096, 16384, 32768, 65536, 131072};
        int k, t, cyc;
        apb(1, OFS_INT_EN_SET, 1);
        for (int c = 0; c < 8; c++)
        begin
            cyc = $time / 40;
            apb(1, OFS_XTAL_CFG, (c << 8) | 2);
            k = 0;
            do begin apb(0, OFS_STATUS, 0); k++; end while (rd[0] !== 1'b1 && k < 400);
            if (rd[0] !== 1'b1) begin miscompares++; test_done; end
            cyc = $time / 40 - cyc;
            t = (n[c] >> SH) < 1 ? 1 : n[c] >> SH;
            `CHK(cyc >= (t - 1) * 4 + 12, 1'b1)
            `CHK(cyc <= t * 4 + 18 + 24, 1'b1)
            settle(10); `CHK(irq, 1'b1)
            apb(1, OFS_XTAL_CFG, 0); apb(0, OFS_STATUS, 0); apb(0, OFS_STATUS, 0);
            apb(0, OFS_STATUS, 0);
            `CHK(rd[0], 1'b0)
            apb(0, OFS_INT_FLAGS, 0); `CHK(rd[0], 1'b1)
            apb(1, OFS_INT_FLAGS, 1);
        end
        apb(1, OFS_INT_EN_CLR, 7);
    endtask
    task automatic sr(input logic s, input logic r, input logic e);
        @(posedge pclk);
        {sby, req} <= {s, r};
        repeat (3) @(posedge pclk);
        `CHK(run, e)
    endtask
    task t_standby;
        apb(1, OFS_XTAL_CFG, 32'h82); sr(1, 0, 0); sr(1, 1, 1); sr(1, 0, 0);
        apb(1, OFS_XTAL_CFG, 32'h02); sr(1, 0, 1); sr(0, 0, 1);
        apb(1, OFS_XTAL_CFG, 0);
    endtask
    // lock freezes config and itself; only a reset reopens it
    task t_lock;
        apb(1, OFS_XTAL_CFG, 32'h105C); apb(0, OFS_XTAL_CFG, 0); `CHK(rd, 32'h105C)
        apb(1, OFS_XTAL_CFG, 32'h0082); apb(0, OFS_XTAL_CFG, 0); `CHK(rd, 32'h105C)
        `CHK({xmode, full_g, slow_g, rsleep}, 4'hF)
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_XTAL_CFG, 0); `CHK(rd, 32'h80)
        `CHK({xmode, full_g, slow_g, rsleep}, 4'h0)
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {ref_clk, xtal_clk, rc_pin, fail_pin, sby, req, rc} = '0;
        {miscompares, samples_checked} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs; t_flag(1); t_flag(2); t_warm; t_standby; t_lock;
        test_done;
    end
endmodule
